// [rtl/sptu_serial_port_unit.sv]
`timescale 1ns/10ps
// What this block does
// - writing the buffer location loads the transmit holding register and starts sending
// - reading the buffer location returns the received byte; transmit data unreadable
// - received byte is buffered so the next byte can shift in meanwhile
// - interrupt requested while enabled and transmit-done or receive-done is set
// - done flags stay set until software clears them
// - transmit bit clock comes from 8-bit auto-reload timer overflows
// - hidden receive timer mirrors the baud timer, same enable and reload
// - both timer overflow streams are halved to form bit rates
// - start edge on receive input forces receive timer reload
// - overflow rate is timer clock over 256 minus reload; baud is half
// - timer clock picks core, core/4, /12, /48, oscillator/8 or external input
// - control bit 7 is stored as written but not used; framing is always 8-bit
// - frame is start bit, eight data bits LSB first, stop bit
// - bits leave on serial output LSB first, arrive on serial input
// - transmit-done sets as the stop bit begins
// - reception starts only while receive enable bit 4 is one
// - byte accepted only if receive-done clear and stop valid when checked
// - on accept: data to buffer, stop bit to extra bit, set receive-done
// - on reject: buffer and extra bit unchanged, receive-done not set
// - on overrun the first byte is kept and later bits are lost
module sptu_serial_port_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    input wire logic ext_osc_clk,
    input wire logic timer_external_input,
    output logic serial_irq
);
    sptu_pkg::sptu_state_t st;
    sptu_pkg::sptu_state_t next_st;

    // one step of an 8-bit auto-reload counter: {overflow, next count}
    function automatic logic [8:0] timer_step(input logic [7:0] count,
                                              input logic [7:0] reload,
                                              input logic tick);
        if (!tick) begin
            timer_step = {1'b0, count};
        end else if (count == sptu_pkg::TIMER_TOP) begin
            timer_step = {1'b1, reload};
        end else begin
            timer_step = {1'b0, count + 8'h01};
        end
    endfunction

    function automatic logic pre_hit(input logic [5:0] pre, input logic [5:0] div);
        pre_hit = ((pre + 6'h01) % div) == 6'h00;
    endfunction

    logic access;
    logic wr;
    logic tick;
    logic [8:0] tx_step;
    logic [8:0] rx_step;
    logic tx_bit_tick;
    logic rx_sample;
    logic start_edge;
    logic tx_done_set;
    logic rx_done_set;
    logic [2:0] src;

    always_comb begin
        next_st = st;
        access = psel && penable && !st.ready;
        wr = psel && penable && st.ready && pwrite;
        src = st.cfg[sptu_pkg::CFG_SRC_LSB +: 3];
        tx_done_set = 1'b0;
        rx_done_set = 1'b0;

        // timer clock source selection
        next_st.pre = (st.pre == sptu_pkg::PRE_TOP) ? 6'h00 : st.pre + 6'h01;
        next_st.osc_prev = ext_osc_clk;
        next_st.ext_prev = timer_external_input;
        next_st.rx_prev = serial_in_pin;
        if (ext_osc_clk && !st.osc_prev) begin
            next_st.osc_cnt = st.osc_cnt + 3'h1;
        end
        unique case (src)
            sptu_pkg::SRC_CORE: tick = 1'b1;
            sptu_pkg::SRC_DIV4: tick = pre_hit(st.pre, sptu_pkg::PRE_DIV4);
            sptu_pkg::SRC_DIV12: tick = pre_hit(st.pre, sptu_pkg::PRE_DIV12);
            sptu_pkg::SRC_DIV48: tick = st.pre == sptu_pkg::PRE_TOP;
            sptu_pkg::SRC_EXT_OSC: tick = ext_osc_clk && !st.osc_prev
                                          && st.osc_cnt == sptu_pkg::OSC_DIV_TOP;
            sptu_pkg::SRC_EXT_IN: tick = !timer_external_input && st.ext_prev;
            default: tick = 1'b0;
        endcase
        tick = tick && st.cfg[sptu_pkg::CFG_RUN];

        // transmit timer and halving
        tx_step = timer_step(st.tx_count, st.reload, tick);
        next_st.tx_count = tx_step[7:0];
        if (tx_step[8]) begin
            next_st.tx_half = !st.tx_half;
        end
        tx_bit_tick = tx_step[8] && st.tx_half;

        // receive timer: same reload, forced reload on start edge
        start_edge = st.rx_phase == sptu_pkg::SPTU_IDLE && st.rx_prev && !serial_in_pin
                     && st.control[sptu_pkg::CTL_RX_ENABLE];
        rx_step = timer_step(st.rx_count, st.reload, tick);
        rx_sample = rx_step[8] && !st.rx_half;
        if (start_edge) begin
            next_st.rx_count = st.reload;
            next_st.rx_half = 1'b0;
        end else begin
            next_st.rx_count = rx_step[7:0];
            if (rx_step[8]) begin
                next_st.rx_half = !st.rx_half;
            end
        end

        // transmitter
        unique case (st.tx_phase)
            sptu_pkg::SPTU_IDLE: begin
                next_st.tx_line = 1'b1;
                if (st.tx_pending && tx_bit_tick) begin
                    next_st.tx_pending = 1'b0;
                    next_st.tx_shift = st.tx_hold;
                    next_st.tx_line = 1'b0;
                    next_st.tx_phase = sptu_pkg::SPTU_START;
                end
            end
            sptu_pkg::SPTU_START: begin
                if (tx_bit_tick) begin
                    next_st.tx_line = st.tx_shift[0];
                    next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
                    next_st.tx_bit = 3'h0;
                    next_st.tx_phase = sptu_pkg::SPTU_DATA;
                end
            end
            sptu_pkg::SPTU_DATA: begin
                if (tx_bit_tick) begin
                    if (st.tx_bit == sptu_pkg::LAST_DATA_BIT) begin
                        next_st.tx_line = 1'b1;
                        tx_done_set = 1'b1;
                        next_st.tx_phase = sptu_pkg::SPTU_STOP;
                    end else begin
                        next_st.tx_line = st.tx_shift[0];
                        next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
                        next_st.tx_bit = st.tx_bit + 3'h1;
                    end
                end
            end
            sptu_pkg::SPTU_STOP: begin
                if (tx_bit_tick) begin
                    next_st.tx_phase = sptu_pkg::SPTU_IDLE;
                end
            end
        endcase

        // receiver; shift register apart from the buffer
        unique case (st.rx_phase)
            sptu_pkg::SPTU_IDLE: begin
                if (start_edge) begin
                    next_st.rx_phase = sptu_pkg::SPTU_START;
                end
            end
            sptu_pkg::SPTU_START: begin
                if (rx_sample) begin
                    // a high line at mid start bit is a glitch, not a frame
                    next_st.rx_phase = serial_in_pin ? sptu_pkg::SPTU_IDLE
                                                     : sptu_pkg::SPTU_DATA;
                    next_st.rx_bit = 3'h0;
                end
            end
            sptu_pkg::SPTU_DATA: begin
                if (rx_sample) begin
                    next_st.rx_shift = {serial_in_pin, st.rx_shift[7:1]};
                    next_st.rx_bit = st.rx_bit + 3'h1;
                    if (st.rx_bit == sptu_pkg::LAST_DATA_BIT) begin
                        next_st.rx_phase = sptu_pkg::SPTU_STOP;
                    end
                end
            end
            sptu_pkg::SPTU_STOP: begin
                if (rx_sample) begin
                    next_st.rx_phase = sptu_pkg::SPTU_IDLE;
                    if (!st.control[sptu_pkg::CTL_RX_DONE]
                        && (!st.control[sptu_pkg::CTL_STOP_CHECK] || serial_in_pin)) begin
                        next_st.rx_buffer = st.rx_shift;
                        next_st.control[sptu_pkg::CTL_EXTRA] = serial_in_pin;
                        rx_done_set = 1'b1;
                    end
                    // otherwise buffer held: overrun keeps the first byte
                end
            end
        endcase

        // apb access: one wait state, then pready
        next_st.ready = access;
        next_st.slverr = 1'b0;
        if (access) begin
            next_st.rdata = 32'h0000_0000;
            unique case (paddr)
                sptu_pkg::ADDR_CONTROL: next_st.rdata[7:0] = st.control;
                sptu_pkg::ADDR_BUFFER: next_st.rdata[7:0] = st.rx_buffer;
                sptu_pkg::ADDR_RELOAD: next_st.rdata[7:0] = st.reload;
                sptu_pkg::ADDR_TIMER_CFG: next_st.rdata[4:0] = st.cfg;
                sptu_pkg::ADDR_LOW_COUNT: next_st.rdata[7:0] = st.tx_count;
                default: next_st.slverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                sptu_pkg::ADDR_CONTROL: begin
                    next_st.control = pwdata[7:0];
                    next_st.control[sptu_pkg::CTL_UNUSED_ONE] = 1'b1;
                    if (rx_done_set) begin
                        next_st.control[sptu_pkg::CTL_EXTRA] = serial_in_pin;
                    end
                end
                sptu_pkg::ADDR_BUFFER: begin
                    next_st.tx_hold = pwdata[7:0];
                    next_st.tx_pending = 1'b1;
                end
                sptu_pkg::ADDR_RELOAD: next_st.reload = pwdata[7:0];
                sptu_pkg::ADDR_TIMER_CFG: next_st.cfg = pwdata[4:0];
                sptu_pkg::ADDR_LOW_COUNT: next_st.tx_count = pwdata[7:0];
                default: next_st.slverr = 1'b0;
            endcase
        end
        // hardware set beats a software clear in the same cycle
        if (tx_done_set) begin
            next_st.control[sptu_pkg::CTL_TX_DONE] = 1'b1;
        end
        if (rx_done_set) begin
            next_st.control[sptu_pkg::CTL_RX_DONE] = 1'b1;
        end
        next_st.irq = next_st.cfg[sptu_pkg::CFG_IRQ_EN]
                      && (next_st.control[sptu_pkg::CTL_TX_DONE]
                          || next_st.control[sptu_pkg::CTL_RX_DONE]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.control <= sptu_pkg::CONTROL_RESET;
            st.tx_line <= 1'b1;
            st.osc_prev <= 1'b1;
            st.ext_prev <= 1'b1;
            st.rx_prev <= 1'b1;
            st.tx_phase <= sptu_pkg::SPTU_IDLE;
            st.rx_phase <= sptu_pkg::SPTU_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign serial_out_pin = st.tx_line;
    assign serial_irq = st.irq;
endmodule

// [rtl/sptu_pkg.sv]
package sptu_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_BUFFER = 8'h04;
    localparam logic [7:0] ADDR_RELOAD = 8'h08;
    localparam logic [7:0] ADDR_TIMER_CFG = 8'h0C;
    localparam logic [7:0] ADDR_LOW_COUNT = 8'h10;

    localparam int CTL_FRAME_LEN = 7;
    localparam int CTL_UNUSED_ONE = 6;
    localparam int CTL_STOP_CHECK = 5;
    localparam int CTL_RX_ENABLE = 4;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_EXTRA = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h40;

    localparam int CFG_RUN = 0;
    localparam int CFG_SRC_LSB = 1;
    localparam int CFG_IRQ_EN = 4;

    localparam logic [2:0] SRC_CORE = 3'h0;
    localparam logic [2:0] SRC_DIV4 = 3'h1;
    localparam logic [2:0] SRC_DIV12 = 3'h2;
    localparam logic [2:0] SRC_DIV48 = 3'h3;
    localparam logic [2:0] SRC_EXT_OSC = 3'h4;
    localparam logic [2:0] SRC_EXT_IN = 3'h5;

    localparam logic [5:0] PRE_TOP = 6'h2F;
    localparam logic [5:0] PRE_DIV4 = 6'h04;
    localparam logic [5:0] PRE_DIV12 = 6'h0C;
    localparam logic [2:0] OSC_DIV_TOP = 3'h7;
    localparam logic [7:0] TIMER_TOP = 8'hFF;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    typedef enum logic [1:0] {
        SPTU_IDLE = 2'h0,
        SPTU_START = 2'h1,
        SPTU_DATA = 2'h3,
        SPTU_STOP = 2'h2
    } sptu_phase_t;

    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic irq;
        logic [7:0] control;
        logic [7:0] reload;
        logic [4:0] cfg;
        logic [7:0] tx_count;
        logic [7:0] rx_count;
        logic tx_half;
        logic rx_half;
        logic [5:0] pre;
        logic [2:0] osc_cnt;
        logic osc_prev;
        logic ext_prev;
        logic rx_prev;
        sptu_phase_t tx_phase;
        logic tx_pending;
        logic [7:0] tx_hold;
        logic [7:0] tx_shift;
        logic [2:0] tx_bit;
        logic tx_line;
        sptu_phase_t rx_phase;
        logic [7:0] rx_shift;
        logic [2:0] rx_bit;
        logic [7:0] rx_buffer;
    } sptu_state_t;
endpackage

// [tb/sptu_serial_port_unit_assertions.sv]
`timescale 1ns/10ps
module sptu_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic ext_osc_clk,
    input wire logic timer_external_input,
    input wire logic serial_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic wr_buf;
    logic sent;
    logic irqen;
    assign wr = psel && penable && pready && pwrite;
    assign wr_buf = wr && paddr == sptu_pkg::ADDR_BUFFER;
    // shadows of bus writes, so the checker needs no internal state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sent <= 1'b0;
            irqen <= 1'b0;
        end else begin
            if (wr_buf) begin
                sent <= 1'b1;
            end
            if (wr && paddr == sptu_pkg::ADDR_TIMER_CFG) begin
                irqen <= pwdata[sptu_pkg::CFG_IRQ_EN];
            end
        end
    end
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_READY_CAUSE: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without access phase");
    AST_READY_ONE_WAIT: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("pready not in second access cycle");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    AST_RESET_IDLE: assert property ($rose(presetn) |-> serial_out_pin && !serial_irq)
        else $error("outputs not idle after reset");
    AST_QUIET_TX: assert property (!sent |-> serial_out_pin)
        else $error("line active without a buffer write");
    AST_WRITE_STARTS: assert property (wr_buf && serial_out_pin |-> ##[1:400] !serial_out_pin)
        else $error("buffer write sent no start bit");
    AST_IRQ_MASK: assert property (!irqen && !$past(irqen) |-> !serial_irq)
        else $error("interrupt while disabled");
    AST_IRQ_NEEDS_EN: assert property (serial_irq |-> irqen)
        else $error("interrupt without enable");
endmodule
bind sptu_serial_port_unit sptu_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .ext_osc_clk(ext_osc_clk),
    .timer_external_input(timer_external_input), .serial_irq(serial_irq));

// [tb/sptu_remote.sv]
`timescale 1ns/10ps
module sptu_remote (
    input wire logic clk,
    input wire logic line_from_dut,
    output logic line_to_dut
);
    int bitc = 4;
    int n_got = 0;
    logic [7:0] got;
    initial line_to_dut = 1'b1;
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_to_dut <= f[i];
            repeat (bitc) @(posedge clk);
        end
        line_to_dut <= 1'b1;
        // one idle edge, so back-to-back sends never drive the line twice in one step
        @(posedge clk);
    endtask
    // sampled on the falling clock edge, clear of the line's launch edge
    always begin
        @(negedge line_from_dut);
        repeat (bitc / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bitc) @(negedge clk);
            got[i] = line_from_dut;
        end
        repeat (bitc) @(negedge clk);
        n_got++;
    end
endmodule

// [tb/test_uart_8bit_with_baud_timer.sv]
`timescale 1ns/10ps
module test_uart_8bit_with_baud_timer;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic serial_in_pin;
    logic serial_out_pin;
    logic serial_irq;
    logic ext_osc_clk = 1'b0;
    logic timer_external_input = 1'b1;
    int errors = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] rl [7] = '{8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'hFD};
    int bc [7] = '{4, 16, 48, 192, 64, 8, 6};
    always #50 pclk = ~pclk;
    // free-running sources for the oscillator and external timer inputs
    always @(posedge pclk) begin
        ext_osc_clk <= ~ext_osc_clk;
        timer_external_input <= ~timer_external_input;
    end
    sptu_serial_port_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .ext_osc_clk(ext_osc_clk), .timer_external_input(timer_external_input),
        .serial_irq(serial_irq));
    sptu_remote u_far (.clk(pclk), .line_from_dut(serial_out_pin), .line_to_dut(serial_in_pin));
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one idle edge first, so psel is never assigned twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no limit here: a hung slave is caught by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(sptu_pkg::ADDR_CONTROL, 32'h40);
        rdchk(sptu_pkg::ADDR_RELOAD, 32'h0);
        rdchk(sptu_pkg::ADDR_TIMER_CFG, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, sptu_pkg::ADDR_LOW_COUNT, 32'h5A);
        rdchk(sptu_pkg::ADDR_LOW_COUNT, 32'h5A);
        $display("test reset ended");
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, sptu_pkg::ADDR_RELOAD, {24'h0, rl[i]});
            apb(1'b1, sptu_pkg::ADDR_TIMER_CFG, 32'h11 | ((i % 6) << 1));
            u_far.bitc = bc[i];
            apb(1'b1, sptu_pkg::ADDR_CONTROL, 32'h0);
            apb(1'b1, sptu_pkg::ADDR_BUFFER, 32'hA5 ^ i);
            for (int t = 0; t < 4000 && u_far.n_got != i + 1; t++) @(posedge pclk);
            chk({24'h0, u_far.got}, 32'hA5 ^ i);
            rdchk(sptu_pkg::ADDR_CONTROL, 32'h42);
            chk({31'h0, serial_irq}, 32'h1);
        end
        rdchk(sptu_pkg::ADDR_BUFFER, 32'h0);
        $display("test transmit ended");
        u_far.bitc = 4;
        apb(1'b1, sptu_pkg::ADDR_TIMER_CFG, 32'h11);
        apb(1'b1, sptu_pkg::ADDR_RELOAD, 32'hFE);
        apb(1'b1, sptu_pkg::ADDR_CONTROL, 32'h10);
        rdchk(sptu_pkg::ADDR_CONTROL, 32'h50);
        chk({31'h0, serial_irq}, 32'h0);
        u_far.send(8'h3C, 1'b1);
        rdchk(sptu_pkg::ADDR_CONTROL, 32'h55);
        rdchk(sptu_pkg::ADDR_BUFFER, 32'h3C);
        rdchk(sptu_pkg::ADDR_CONTROL, 32'h55);
        chk({31'h0, serial_irq}, 32'h1);
        u_far.send(8'hC3, 1'b1);
        rdchk(sptu_pkg::ADDR_BUFFER, 32'h3C);
        apb(1'b1, sptu_pkg::ADDR_CONTROL, 32'h30);
        u_far.send(8'h99, 1'b0);
        rdchk(sptu_pkg::ADDR_CONTROL, 32'h70);
        rdchk(sptu_pkg::ADDR_BUFFER, 32'h3C);
        apb(1'b1, sptu_pkg::ADDR_CONTROL, 32'h10);
        u_far.send(8'h5A, 1'b0);
        rdchk(sptu_pkg::ADDR_CONTROL, 32'h51);
        apb(1'b1, sptu_pkg::ADDR_CONTROL, 32'h00);
        u_far.send(8'h77, 1'b1);
        rdchk(sptu_pkg::ADDR_CONTROL, 32'h40);
        rdchk(sptu_pkg::ADDR_BUFFER, 32'h5A);
        apb(1'b1, sptu_pkg::ADDR_CONTROL, 32'h10);
        u_far.send(8'h11, 1'b1);
        fork
            u_far.send(8'h22, 1'b1);
            begin
                rdchk(sptu_pkg::ADDR_BUFFER, 32'h11);
                apb(1'b1, sptu_pkg::ADDR_CONTROL, 32'h10);
            end
        join
        rdchk(sptu_pkg::ADDR_BUFFER, 32'h22);
        apb(1'b1, sptu_pkg::ADDR_TIMER_CFG, 32'h01);
        rdchk(sptu_pkg::ADDR_CONTROL, 32'h55);
        chk({31'h0, serial_irq}, 32'h0);
        $display("test receive ended");
        results();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        results();
    end
endmodule
